// >>> design/cee_pkg.sv
// Constants and types shared by the capacity estimation engine
package cee_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned PASS_INTERVAL_MS = 3500;
  localparam int unsigned PASS_CYCLES      = PASS_INTERVAL_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ACC_W  = 16;
  localparam int RD_W   = 16;
  localparam int AS_W   = 8;
  localparam int FULL_W = 15;
  localparam int EMP_W  = 13;
  localparam int PCT_W  = 8;
  localparam int AGE_W  = 24;

  // ----------------------------------------
  // Fixed-point layout and reset values
  // ----------------------------------------
  localparam int FRAC_SHIFT = 14;
  localparam int AS_SHIFT   = 7;
  localparam int AGE_MULT_SHIFT = 5;
  localparam logic [FULL_W-1:0] FULL_ONE       = 15'h4000;
  localparam logic [AS_W-1:0]   AS_RESET       = 8'h80;
  localparam logic [AS_W-1:0]   AS_MAX         = 8'hFF;
  localparam logic [PCT_W-1:0]  PCT_MAX        = 8'hFF;
  localparam logic [PCT_W-1:0]  PCT_FULL_CLEAR = 8'h5A;
  localparam logic [PCT_W-1:0]  PCT_AE_CLEAR   = 8'h05;
  localparam logic [15:0]       PCT_SCALE      = 16'h0064;
  localparam logic [ACC_W-1:0]  ACC_MAX        = 16'hFFFF;

  // ----------------------------------------
  // Result pass sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    CEE_IDLE = 2'b00,
    CEE_FRAC = 2'b01,
    CEE_ABS  = 2'b11,
    CEE_REL  = 2'b10
  } cee_state_e;

endpackage

// >>> design/cee_engine.sv
// Capacity estimation engine: aging, learn cycle, housekeeping, results
//
// Functional notes
// - Age scaler drops after 32x aging capacity
// - Learn valid only with uninterrupted charge
// - Full in learn: clear learn, set full
// - Full loads accumulator with scaled full
// - Age scaler updated before accumulator correction
// - Empty without learn: clamp accumulator down
// - Empty with learn: load active-empty value
// - Full: voltage high, averages below minimum
// - Both averages must be positive, nonzero
// - Full detection sets charged-to-full flag
// - Active empty: low voltage, heavy discharge
// - Active empty detection sets learn flag
// - Seven results computed every 3.5 s
// - Full fraction clamped to 100 percent
// - Active-empty fraction from cell model
// - Standby-empty fraction from cell model
// - Active mAh from accumulator and conductance
// - Standby mAh from accumulator and conductance
// - Active percent relative to scaled full
// - Standby percent relative to scaled full
// - Age scaler 8 bits, 80h unaged
// - Full flag clears below 90 percent
// - Active-empty flag clears above 5 percent
// - Learn clears on full or discharge
`timescale 1ns/1ps
`default_nettype none

module cee_engine
  import cee_pkg::*;
#(
  parameter int unsigned PASS_CYC  = cee_pkg::PASS_CYCLES,
  parameter int          MAH_SHIFT = 8
)
(
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  // Measurements
  input  wire logic                         voltage_valid_in,
  input  wire logic [cee_pkg::RD_W-1:0]     voltage_reading_in,
  input  wire logic                         current_valid_in,
  input  wire logic signed [cee_pkg::RD_W-1:0] current_reading_in,
  input  wire logic                         average_valid_in,
  input  wire logic signed [cee_pkg::RD_W-1:0] average_current_in,
  // Coulomb count steps
  input  wire logic                         acc_step_in,
  input  wire logic signed [cee_pkg::ACC_W-1:0] acc_delta_in,
  // Application parameters
  input  wire logic [cee_pkg::RD_W-1:0]     charge_voltage_threshold_in,
  input  wire logic [cee_pkg::RD_W-1:0]     minimum_charge_current_in,
  input  wire logic [cee_pkg::RD_W-1:0]     active_empty_voltage_in,
  input  wire logic [cee_pkg::RD_W-1:0]     active_empty_current_in,
  input  wire logic [cee_pkg::ACC_W-1:0]    aging_capacity_in,
  input  wire logic [cee_pkg::ACC_W-1:0]    full_value_at_50c_in,
  input  wire logic [7:0]                   sense_conductance_in,
  // Cell model lookup at present temperature
  input  wire logic [15:0]                  full_lookup_in,
  input  wire logic [cee_pkg::EMP_W-1:0]    active_empty_lookup_in,
  input  wire logic [cee_pkg::EMP_W-1:0]    standby_empty_lookup_in,
  // Host write of age scaler
  input  wire logic                         age_scaler_load_in,
  input  wire logic [cee_pkg::AS_W-1:0]     age_scaler_wdata_in,
  // State
  output logic [cee_pkg::ACC_W-1:0]         coulomb_accumulator_out,
  output logic [cee_pkg::AS_W-1:0]          age_scaler_out,
  output logic                              charged_to_full_flag_out,
  output logic                              active_empty_flag_out,
  output logic                              learn_flag_out,
  output logic                              pass_done_out,
  // Results
  output logic [cee_pkg::FULL_W-1:0]        full_fraction_at_temp_out,
  output logic [cee_pkg::EMP_W-1:0]         active_empty_fraction_at_temp_out,
  output logic [cee_pkg::EMP_W-1:0]         standby_empty_fraction_at_temp_out,
  output logic [15:0]                       remaining_active_mah_out,
  output logic [15:0]                       remaining_standby_mah_out,
  output logic [cee_pkg::PCT_W-1:0]         remaining_active_percent_out,
  output logic [cee_pkg::PCT_W-1:0]         remaining_standby_percent_out
);

  import cee_pkg::*;

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    cee_state_e        state;
    logic [31:0]       pass_cnt;
    logic              pass_done;
    logic [ACC_W-1:0]  acc;
    logic [AS_W-1:0]   age_scaler;
    logic [AGE_W-1:0]  age_cnt;
    logic              full_flg;
    logic              empty_flg;
    logic              learn_flg;
    logic              voltage_reading_was_above;
    logic              voltage_reading_high_run;
    logic              prev_avg_ok;
    logic              heavy1;
    logic              heavy2;
    logic [FULL_W-1:0] full_t;
    logic [EMP_W-1:0]  ae_t;
    logic [EMP_W-1:0]  se_t;
    logic [15:0]       act_mah;
    logic [15:0]       stb_mah;
    logic [PCT_W-1:0]  act_pct;
    logic [PCT_W-1:0]  stb_pct;
  } cee_regs_s;

  cee_regs_s r_reg;
  cee_regs_s r_next;

  // ----------------------------------------
  // Capacity helpers
  // ----------------------------------------
  // Fraction (2^-14) of the 50C full value, in accumulator units
  function automatic logic [17:0] frac_amount(input logic [15:0] frac,
                                              input logic [15:0] full_value_at_50c);
    logic [31:0] prod;
    prod = {16'h0000, frac} * {16'h0000, full_value_at_50c};
    return prod[31:14];
  endfunction

  // Age-scaled full fraction, still 2^-14 units
  function automatic logic [15:0] scaled_frac(input logic [AS_W-1:0] as_v,
                                              input logic [FULL_W-1:0] full_v);
    logic [22:0] prod;
    prod = {15'h0000, as_v} * {8'h00, full_v};
    return prod[22:7];
  endfunction

  function automatic logic [ACC_W-1:0] sat_acc(input logic [17:0] v);
    return (v > {2'b00, ACC_MAX}) ? ACC_MAX : v[ACC_W-1:0];
  endfunction

  // Remaining capacity above an empty point, floored at zero
  function automatic logic [17:0] above(input logic [ACC_W-1:0] acc_v,
                                        input logic [17:0] empty_amt);
    return ({2'b00, acc_v} > empty_amt) ? ({2'b00, acc_v} - empty_amt) : 18'h00000;
  endfunction

  function automatic logic [15:0] to_mah(input logic [17:0] amt,
                                         input logic [7:0] cond);
    logic [25:0] prod;
    logic [25:0] shifted;
    prod    = {8'h00, amt} * {18'h00000, cond};
    shifted = prod >> MAH_SHIFT;
    return (shifted > 26'h000FFFF) ? 16'hFFFF : shifted[15:0];
  endfunction

  function automatic logic [PCT_W-1:0] to_pct(input logic [17:0] amt,
                                              input logic [17:0] span);
    logic [33:0] num;
    logic [33:0] quo;
    num = {16'h0000, amt} * {18'h00000, PCT_SCALE};
    quo = (span == 18'h00000) ? 34'h000000000 : num / {16'h0000, span};
    return (quo > {26'h0000000, PCT_MAX}) ? PCT_MAX : quo[PCT_W-1:0];
  endfunction

  // ----------------------------------------
  // Present-temperature model values
  // ----------------------------------------
  logic [FULL_W-1:0] full_now;
  logic [17:0]       ae_amt_now;
  logic [17:0]       full_amt_now;
  logic [17:0]       learned_base;
  logic [25:0]       learned_ratio;
  logic [AS_W-1:0]   as_learned;
  logic [ACC_W-1:0]  acc_full_learned;
  logic [ACC_W-1:0]  acc_full_plain;

  always_comb
  begin
    full_now = (full_lookup_in > {1'b0, FULL_ONE}) ? FULL_ONE : full_lookup_in[FULL_W-1:0];
    ae_amt_now   = frac_amount({3'b000, active_empty_lookup_in}, full_value_at_50c_in);
    full_amt_now = frac_amount({1'b0, full_now}, full_value_at_50c_in);
    learned_base  = full_amt_now;
    learned_ratio = ({10'h000, r_reg.acc} << AS_SHIFT);
    learned_ratio = (learned_base == 18'h00000) ? {18'h00000, r_reg.age_scaler}
                    : learned_ratio / {8'h00, learned_base};
    as_learned = (learned_ratio > {18'h00000, AS_MAX}) ? AS_MAX : learned_ratio[AS_W-1:0];
    acc_full_learned = sat_acc(frac_amount(scaled_frac(as_learned, full_now),
                                           full_value_at_50c_in));
    acc_full_plain   = sat_acc(frac_amount(scaled_frac(r_reg.age_scaler, full_now),
                                           full_value_at_50c_in));
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic              avg_ok;
  logic              full_hit;
  logic              voltage_reading_low;
  logic              cur_heavy;
  logic [ACC_W-1:0]  dec_amt;
  logic [AGE_W-1:0]  age_limit;
  logic [17:0]       ae_amt;
  logic [17:0]       se_amt;
  logic [17:0]       full_amt;

  always_comb
  begin
    r_next    = r_reg;
    r_next.pass_done = 1'b0;
    avg_ok    = (average_current_in > $signed(16'h0000))
                && ($unsigned(average_current_in) < minimum_charge_current_in);
    voltage_reading_low  = voltage_reading_in < active_empty_voltage_in;
    cur_heavy = (current_reading_in < $signed(16'h0000))
                && ($unsigned(-current_reading_in) > active_empty_current_in);
    dec_amt   = (acc_delta_in < $signed(16'h0000)) ? $unsigned(-acc_delta_in) : 16'h0000;
    age_limit = {8'h00, aging_capacity_in} << AGE_MULT_SHIFT;
    full_hit  = 1'b0;
    ae_amt    = frac_amount({3'b000, r_reg.ae_t}, full_value_at_50c_in);
    se_amt    = frac_amount({3'b000, r_reg.se_t}, full_value_at_50c_in);
    full_amt  = frac_amount(scaled_frac(r_reg.age_scaler, r_reg.full_t),
                            full_value_at_50c_in);

    // Coulomb count, floored at zero and capped at full scale
    if (acc_step_in)
    begin
      if (acc_delta_in < $signed(16'h0000))
      begin
        r_next.acc = (r_reg.acc > dec_amt) ? r_reg.acc - dec_amt : 16'h0000;
        if (r_reg.age_cnt + {8'h00, dec_amt} >= age_limit)
        begin
          r_next.age_cnt    = '0;
          r_next.age_scaler = (r_reg.age_scaler != 8'h00) ? r_reg.age_scaler - 8'h01 : 8'h00;
        end
        else
        begin
          r_next.age_cnt = r_reg.age_cnt + {8'h00, dec_amt};
        end
      end
      else
      begin
        r_next.acc = sat_acc({2'b00, r_reg.acc} + {2'b00, $unsigned(acc_delta_in)});
      end
    end

    if (age_scaler_load_in)
    begin
      r_next.age_scaler = age_scaler_wdata_in;
    end

    if (current_valid_in)
    begin
      r_next.heavy1 = cur_heavy;
      r_next.heavy2 = r_reg.heavy1;
      if (current_reading_in < $signed(16'h0000))
      begin
        r_next.learn_flg = 1'b0;
      end
    end

    if (voltage_valid_in && voltage_reading_in <= charge_voltage_threshold_in)
    begin
      r_next.voltage_reading_high_run = 1'b0;
    end
    if (average_valid_in)
    begin
      full_hit = avg_ok && r_reg.prev_avg_ok && r_reg.voltage_reading_high_run
                 && !(voltage_valid_in && voltage_reading_in <= charge_voltage_threshold_in);
      r_next.prev_avg_ok   = avg_ok;
      r_next.voltage_reading_high_run = 1'b1;
    end

    // Active empty point on a falling voltage
    if (voltage_valid_in)
    begin
      r_next.voltage_reading_was_above = !voltage_reading_low;
      if (voltage_reading_low)
      begin
        r_next.empty_flg = 1'b1;
        if (r_reg.voltage_reading_was_above && r_reg.heavy1 && r_reg.heavy2)
        begin
          r_next.learn_flg = 1'b1;
          r_next.acc = sat_acc(ae_amt_now);
        end
        else if (r_reg.learn_flg || ({2'b00, r_next.acc} > ae_amt_now))
        begin
          r_next.acc = sat_acc(ae_amt_now);
        end
      end
    end

    if (full_hit)
    begin
      r_next.full_flg  = 1'b1;
      r_next.learn_flg = 1'b0;
      if (r_reg.learn_flg)
      begin
        r_next.age_scaler = as_learned;
        r_next.acc        = acc_full_learned;
        r_next.age_cnt    = '0;
      end
      else
      begin
        r_next.acc = acc_full_plain;
      end
    end

    // Periodic result pass
    // Counter runs through the stages too, so the period is exact
    r_next.pass_cnt = r_reg.pass_cnt + 32'h00000001;
    unique case (r_reg.state)
      CEE_IDLE:
      begin
        if (r_reg.pass_cnt >= PASS_CYC - 1)
        begin
          r_next.pass_cnt = '0;
          r_next.state    = CEE_FRAC;
        end
      end
      CEE_FRAC:
      begin
        r_next.full_t = full_now;
        r_next.ae_t   = active_empty_lookup_in;
        r_next.se_t   = standby_empty_lookup_in;
        r_next.state  = CEE_ABS;
      end
      CEE_ABS:
      begin
        r_next.act_mah = to_mah(above(r_reg.acc, ae_amt), sense_conductance_in);
        r_next.stb_mah = to_mah(above(r_reg.acc, se_amt), sense_conductance_in);
        r_next.state   = CEE_REL;
      end
      CEE_REL:
      begin
        r_next.act_pct = to_pct(above(r_reg.acc, ae_amt), above(full_amt[15:0], ae_amt));
        r_next.stb_pct = to_pct(above(r_reg.acc, se_amt), above(full_amt[15:0], se_amt));
        // Full flag clears low
        // A detection in the same cycle wins over the clear
        if (r_next.act_pct < PCT_FULL_CLEAR && !full_hit)
        begin
          r_next.full_flg = 1'b0;
        end
        if (r_next.act_pct > PCT_AE_CLEAR && !(voltage_valid_in && voltage_reading_low))
        begin
          r_next.empty_flg = 1'b0;
        end
        r_next.pass_done = 1'b1;
        r_next.state     = CEE_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r_reg <= '0;
      r_reg.age_scaler <= AS_RESET;
      r_reg.state      <= CEE_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Results already floored
  assign coulomb_accumulator_out            = r_reg.acc;
  assign age_scaler_out                     = r_reg.age_scaler;
  assign charged_to_full_flag_out           = r_reg.full_flg;
  assign active_empty_flag_out              = r_reg.empty_flg;
  assign learn_flag_out                     = r_reg.learn_flg;
  assign pass_done_out                      = r_reg.pass_done;
  assign full_fraction_at_temp_out          = r_reg.full_t;
  assign active_empty_fraction_at_temp_out  = r_reg.ae_t;
  assign standby_empty_fraction_at_temp_out = r_reg.se_t;
  assign remaining_active_mah_out           = r_reg.act_mah;
  assign remaining_standby_mah_out          = r_reg.stb_mah;
  assign remaining_active_percent_out       = r_reg.act_pct;
  assign remaining_standby_percent_out      = r_reg.stb_pct;

endmodule

`default_nettype wire

// >>> verification/cee_engine_assertions.sv
// Checker for the capacity estimation engine ports
`timescale 1ns/1ps
`default_nettype none

module cee_engine_assertions
  import cee_pkg::*;
#(
  parameter int unsigned PASS_CYC = 20
)
(
  // Clock and reset
  input wire logic                        clk_in,
  input wire logic                        rst_n_in,
  // Measurements
  input wire logic                        voltage_valid_in,
  input wire logic [cee_pkg::RD_W-1:0]    voltage_reading_in,
  input wire logic                        current_valid_in,
  input wire logic signed [cee_pkg::RD_W-1:0] current_reading_in,
  input wire logic                        average_valid_in,
  input wire logic signed [cee_pkg::RD_W-1:0] average_current_in,
  input wire logic                        acc_step_in,
  input wire logic                        age_scaler_load_in,
  // Thresholds
  input wire logic [cee_pkg::RD_W-1:0]    minimum_charge_current_in,
  input wire logic [cee_pkg::RD_W-1:0]    active_empty_voltage_in,
  // Outputs watched
  input wire logic [cee_pkg::ACC_W-1:0]   coulomb_accumulator_out,
  input wire logic [cee_pkg::AS_W-1:0]    age_scaler_out,
  input wire logic                        charged_to_full_flag_out,
  input wire logic                        active_empty_flag_out,
  input wire logic                        learn_flag_out,
  input wire logic                        pass_done_out,
  input wire logic [cee_pkg::FULL_W-1:0]  full_fraction_at_temp_out,
  input wire logic [cee_pkg::PCT_W-1:0]   remaining_active_percent_out
);
  import cee_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [31:0] gap_reg;
  logic        seen_reg;
  logic        avg_ok;
  // Unsigned compare is safe only once the sign test has passed
  assign avg_ok = average_valid_in && (average_current_in > 16'sh0000)
                  && ($unsigned(average_current_in) < minimum_charge_current_in);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b0;
    end
    else if (pass_done_out)
    begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b1;
    end
    else
      gap_reg <= gap_reg + 32'h1;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_low_voltage_reading;
    voltage_valid_in && (voltage_reading_in < active_empty_voltage_in);
  endsequence
  sequence s_discharge;
    current_valid_in && (current_reading_in < 16'sh0000) && !voltage_valid_in;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_PASS_PERIOD: assert property (pass_done_out && seen_reg |-> gap_reg == PASS_CYC - 1)
    else $error("result pass period wrong");
  AST_PASS_PULSE: assert property (pass_done_out |=> !pass_done_out)
    else $error("pass done longer than one cycle");
  AST_FULL_CLAMP: assert property (full_fraction_at_temp_out <= FULL_ONE)
    else $error("full fraction above one");
  AST_FULL_CAUSE: assert property ($rose(charged_to_full_flag_out) |-> $past(avg_ok))
    else $error("full flag without qualifying average");
  AST_LEARN_ON_FULL: assert property ($rose(charged_to_full_flag_out) |-> !learn_flag_out)
    else $error("learn flag kept at full");
  AST_AE_SET: assert property (s_low_voltage_reading |=> active_empty_flag_out)
    else $error("active empty flag not set");
  AST_LEARN_SET: assert property ($rose(learn_flag_out) |-> $past(voltage_valid_in) && active_empty_flag_out)
    else $error("learn flag set without empty point");
  AST_LEARN_ABORT: assert property (s_discharge |=> !learn_flag_out)
    else $error("learn flag kept on discharge");
  AST_AE_CLAMP: assert property ($rose(active_empty_flag_out) && !learn_flag_out && !$past(acc_step_in)
    |-> coulomb_accumulator_out <= $past(coulomb_accumulator_out))
    else $error("accumulator raised at empty");
  AST_AGE_STEP: assert property ((age_scaler_out != $past(age_scaler_out)) && !$past(age_scaler_load_in)
    && !$rose(charged_to_full_flag_out) |-> age_scaler_out == $past(age_scaler_out) - 8'h01)
    else $error("age scaler step not one");
  AST_AGE_RESET: assert property ($rose(rst_n_in) |-> age_scaler_out == AS_RESET)
    else $error("age scaler reset value wrong");
  AST_FULL_CLEAR: assert property ($fell(charged_to_full_flag_out)
    |-> pass_done_out && remaining_active_percent_out < PCT_FULL_CLEAR)
    else $error("full flag cleared wrongly");
  AST_AE_CLEAR: assert property ($fell(active_empty_flag_out)
    |-> pass_done_out && remaining_active_percent_out > PCT_AE_CLEAR)
    else $error("empty flag cleared wrongly");
endmodule

`default_nettype wire

// >>> verification/cee_host_model.sv
// Host model that reads the active percent result after each pass
`timescale 1ns/1ps
`default_nettype none

module cee_host_model
  import cee_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // Result side
  input  wire logic                      pass_done_in,
  input  wire logic [cee_pkg::PCT_W-1:0] active_percent_in,
  // Host view
  output logic [cee_pkg::PCT_W-1:0]      active_percent_out,
  output logic [15:0]                    read_count_out
);
  import cee_pkg::*;

  // Host reads only once the pass has finished, never a half-updated set
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      active_percent_out <= 8'h00;
      read_count_out     <= 16'h0000;
    end
    else if (pass_done_in)
    begin
      active_percent_out <= active_percent_in;
      read_count_out     <= read_count_out + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// >>> verification/capacity_estimation_engine_tb.sv
// Self-checking testbench for the capacity estimation engine
`timescale 1ns/1ps
`default_nettype none

module capacity_estimation_engine_tb;
  import cee_pkg::*;
  localparam int unsigned PC = 20;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [4:0]  vld      = 5'h00;
  logic [15:0] voltage_reading     = 16'h0000;
  logic [15:0] cur      = 16'h0000;
  logic [15:0] avg      = 16'h0000;
  logic [15:0] dlt      = 16'h0000;
  logic [15:0] agecap   = 16'h0004;
  logic [15:0] vch      = 16'h1000;
  logic [15:0] flu      = 16'h5000;
  logic [12:0] ael      = 13'h0800;
  logic [12:0] sel      = 13'h0400;
  logic [7:0]  cnd      = 8'h10;
  logic [7:0]  asw      = 8'h00;
  logic [15:0] acc, amah, smah, hreads;
  logic [7:0]  age, apct, spct, hpct;
  logic        chg, emp, lrn, pdone;
  logic [14:0] ffr;
  logic [12:0] aefr, sefr;
  int          err_count    = 0;
  int          total_checks = 0;

  always #4 clk_in = ~clk_in;

  // Thresholds held as levels for the whole run; aging capacity, cell model and conductance change mid-run
  cee_engine #(.PASS_CYC(PC), .MAH_SHIFT(8)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .voltage_valid_in(vld[0]), .voltage_reading_in(voltage_reading),
    .current_valid_in(vld[1]), .current_reading_in(cur),
    .average_valid_in(vld[2]), .average_current_in(avg),
    .acc_step_in(vld[3]), .acc_delta_in(dlt),
    .charge_voltage_threshold_in(vch), .minimum_charge_current_in(16'h0100),
    .active_empty_voltage_in(16'h0800), .active_empty_current_in(16'h0200),
    .aging_capacity_in(agecap), .full_value_at_50c_in(16'h4000),
    .sense_conductance_in(cnd), .full_lookup_in(flu),
    .active_empty_lookup_in(ael), .standby_empty_lookup_in(sel),
    .age_scaler_load_in(vld[4]), .age_scaler_wdata_in(asw),
    .coulomb_accumulator_out(acc), .age_scaler_out(age),
    .charged_to_full_flag_out(chg), .active_empty_flag_out(emp),
    .learn_flag_out(lrn), .pass_done_out(pdone),
    .full_fraction_at_temp_out(ffr), .active_empty_fraction_at_temp_out(aefr),
    .standby_empty_fraction_at_temp_out(sefr), .remaining_active_mah_out(amah),
    .remaining_standby_mah_out(smah), .remaining_active_percent_out(apct),
    .remaining_standby_percent_out(spct));

  cee_host_model i_host (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .pass_done_in(pdone),
    .active_percent_in(apct), .active_percent_out(hpct), .read_count_out(hreads));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One event pulse: 0 voltage, 1 current, 2 average, 3 step, 4 host age write
  task automatic send(input int k, input logic [15:0] v);
    @(posedge clk_in);
    case (k)
      0: voltage_reading <= v;
      1: cur <= v;
      2: avg <= v;
      3: dlt <= v;
      default: asw <= v[7:0];
    endcase
    vld[k] <= 1'b1;
    @(posedge clk_in);
    vld <= 5'h00;
    @(negedge clk_in);
  endtask

  // Two passes, so every stage has seen the settled inputs
  task automatic wait_pass;
    repeat (2)
    begin
      for (int i = 0; i < 3 * PC; i++)
      begin
        @(negedge clk_in);
        if (pdone === 1'b1)
          break;
      end
    end
  endtask

  initial
  begin
    #100000;
    err_count++;
    test_done();
  end

  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk(age, 8'h80);
    chk({chg, emp, lrn, acc}, 32'h0);
    // Aging threshold is 32 x 4 of discharge
    send(3, 16'h1000);
    send(3, 16'hFF80);
    chk(age, 8'h7F);
    send(3, 16'hFFC0);
    chk(age, 8'h7F);
    send(3, 16'hFFC0);
    chk(age, 8'h7E);
    @(posedge clk_in) agecap <= 16'hFFFF;
    send(3, 16'h0100);
    wait_pass();
    chk(ffr, 15'h4000);
    chk(aefr, 13'h0800);
    chk(sefr, 13'h0400);
    chk(amah, 16'h0080);
    chk(smah, 16'h00C0);
    chk(hpct, 8'h0E);
    chk(spct, 8'h14);
    // Empty without learn only lowers the count
    send(0, 16'h0700);
    chk({emp, lrn}, 2'b10);
    chk(acc, 16'h0800);
    send(3, 16'hFB00);
    send(0, 16'h0700);
    chk(acc, 16'h0300);
    wait_pass();
    chk({amah, smah}, 32'h0);
    chk({apct, spct}, 32'h0);
    // Falling voltage after two heavy discharge readings
    send(0, 16'h0900);
    send(1, 16'hFD00);
    send(1, 16'hFD00);
    send(0, 16'h0700);
    chk(lrn, 1'b1);
    chk(acc, 16'h0800);
    // Zero average must not qualify the first of the pair
    send(3, 16'h3000);
    send(2, 16'h0000);
    send(0, 16'h1100);
    send(2, 16'h0080);
    chk(chg, 1'b0);
    send(0, 16'h1100);
    send(2, 16'h0080);
    chk({chg, lrn}, 2'b10);
    chk(age, 8'h70);
    chk(acc, 16'h3800);
    wait_pass();
    chk({chg, emp}, 2'b10);
    chk(hpct, 8'h64);
    send(3, 16'hD800);
    wait_pass();
    chk(chg, 1'b0);
    chk(apct, 8'h10);
    send(4, 16'h0055);
    chk(age, 8'h55);
    // Cooler cell model, unclamped, and a larger conductance
    @(posedge clk_in);
    flu <= 16'h3000;
    sel <= 13'h0200;
    cnd <= 8'h20;
    wait_pass();
    chk(ffr, 15'h3000);
    chk(sefr, 13'h0200);
    chk(amah, 16'h0100);
    chk(smah, 16'h01C0);
    chk(hreads > 16'h0000, 1'b1);
    test_done();
  end
endmodule

bind cee_engine cee_engine_assertions #(.PASS_CYC(PASS_CYC)) i_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .voltage_valid_in(voltage_valid_in),
  .voltage_reading_in(voltage_reading_in), .current_valid_in(current_valid_in),
  .current_reading_in(current_reading_in), .average_valid_in(average_valid_in),
  .average_current_in(average_current_in), .acc_step_in(acc_step_in),
  .age_scaler_load_in(age_scaler_load_in), .minimum_charge_current_in(minimum_charge_current_in),
  .active_empty_voltage_in(active_empty_voltage_in),
  .coulomb_accumulator_out(coulomb_accumulator_out), .age_scaler_out(age_scaler_out),
  .charged_to_full_flag_out(charged_to_full_flag_out),
  .active_empty_flag_out(active_empty_flag_out), .learn_flag_out(learn_flag_out),
  .pass_done_out(pass_done_out), .full_fraction_at_temp_out(full_fraction_at_temp_out),
  .remaining_active_percent_out(remaining_active_percent_out));

`default_nettype wire
